// ==== core/cmc_mode_ctrl.sv ====
// module: CAN operating-mode controller with APB register slave
`timescale 1ns/1ps
module cmc_mode_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // bus pins
  input  wire logic        bus_receive_pin,
  output logic             bus_transmit_pin,
  output logic             bus_transmit_oe,
  output logic             bus_pins_owned,
  // power
  input  wire logic        sleep_req,
  // protocol engine inputs
  input  wire logic        engine_tx_bit,
  input  wire logic        engine_tx_busy,
  input  wire logic        engine_tx_done,
  input  wire logic        engine_tx_err,
  input  wire logic        engine_rx_err,
  input  wire logic        engine_err_det,
  input  wire logic        engine_ovl_cond,
  input  wire logic        engine_sof,
  input  wire logic        engine_rtr_hit,
  input  wire logic [1:0]  engine_rtr_buf,
  // protocol engine outputs
  output logic             engine_rx_bit,
  output logic             engine_tx_en,
  output logic             engine_rx_en,
  output logic             engine_ack_en,
  output logic             engine_accept_all,
  output logic             tx_start,
  output logic [1:0]       tx_buf_sel,
  output logic [3:0]       tx_dlc,
  output logic             err_frame_send,
  output logic             ovl_frame_send
);
  typedef struct packed {
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic [2:0]             req;
    logic [2:0]             cur;
    cmc_pkg::cmc_mstate_type mst;
    logic [15:0]            bitper;
    logic                   wake_filter_enable;
    logic [15:0]            intcfg;
    logic [7:0][29:0]       filt;
    logic [2:0][1:0]        pri;
    logic [2:0][3:0]        txdlc;
    logic [2:0]             tx_request_bit;
    logic [2:0]             tx_aborted_flag;
    logic                   wake_int_flag;
    logic [7:0]             tec;
    logic [7:0]             rec;
    logic [15:0]            bcnt;
    logic [3:0]             idle;
    logic                   hold_tx;
    logic                   rx_q;
    logic [1:0]             ovl_run;
    logic                   txact;
    logic [1:0]             sel;
    logic [3:0]             dlc_out;
    logic                   tx_start;
    logic                   err_send;
    logic                   ovl_send;
    logic                   tx_en;
    logic                   rx_en;
    logic                   ack_en;
    logic                   accept_all;
    logic                   eng_rx;
    logic                   pin_tx;
    logic                   pin_oe;
    logic                   pins_owned;
  } cmc_ctrl_state_type;

  cmc_ctrl_state_type s_r;
  cmc_ctrl_state_type s_nxt;

  logic        rx_f;
  logic        lpf_on;
  logic        active;
  logic        cfg_ok;
  logic        access;
  logic        wr_en;
  logic        tick;
  logic [15:0] bit_lim;

  function automatic logic tx_mode(input logic [2:0] m);
    return (m == cmc_pkg::MODE_NORMAL) || (m == cmc_pkg::MODE_LOOPBACK);
  endfunction

  // ==========================================================================
  // receive path filter
  assign lpf_on = s_r.wake_filter_enable &
                  (sleep_req | (s_r.cur == cmc_pkg::MODE_DISABLE));

  cmc_lp_filter u_lpf (
    .pclk      (pclk),
    .presetn   (presetn),
    .filt_on   (lpf_on),
    .raw_in    (bus_receive_pin),
    .clean_out (rx_f)
  );

  // ==========================================================================
  // shared terms
  assign active = (s_r.cur != cmc_pkg::MODE_INIT) &&
                  (s_r.cur != cmc_pkg::MODE_DISABLE);
  assign cfg_ok = (s_r.cur == cmc_pkg::MODE_INIT);
  assign access = psel & penable & ~s_r.pready;
  assign wr_en  = psel & penable & s_r.pready & pwrite;
  // slower rates are fine, faster ones are clamped to the top rate
  assign bit_lim = (s_r.bitper < 16'(cmc_pkg::BIT_CYC_MIN)) ?
                   16'(cmc_pkg::BIT_CYC_MIN) : s_r.bitper;
  assign tick = (s_r.bcnt == bit_lim - 16'h0001);

  // ==========================================================================
  // next state
  always_comb begin
    logic [31:0] rdv;
    logic        map;
    logic        abort_all;
    logic        fnd;
    logic [1:0]  bp;
    logic [1:0]  bi;
    logic [2:0]  nm;
    logic [3:0]  dl;
    rdv       = 32'h0000_0000;
    map       = 1'b1;
    abort_all = 1'b0;
    fnd       = 1'b0;
    bp        = 2'h0;
    bi        = 2'h0;
    nm        = 3'h0;
    dl        = 4'h0;
    s_nxt     = s_r;
    s_nxt.tx_start = 1'b0;
    s_nxt.err_send = 1'b0;
    s_nxt.ovl_send = 1'b0;

    // ---- register read decode
    if (paddr[1:0] != 2'h0) begin
      map = 1'b0;
    end else if (paddr[7:5] == cmc_pkg::ADDR_FILT[7:5]) begin
      rdv = {2'h0, s_r.filt[paddr[4:2]]};
    end else begin
      case (paddr)
        cmc_pkg::ADDR_CTRL: begin
          rdv[cmc_pkg::CTRL_REQ_LSB +: 3] = s_r.req;
          rdv[cmc_pkg::CTRL_CUR_LSB +: 3] = s_r.cur;
        end
        cmc_pkg::ADDR_CFG1:   rdv[15:0] = s_r.bitper;
        cmc_pkg::ADDR_CFG2:   rdv[cmc_pkg::CFG2_WAKE_FILTER_ENABLE_BIT] = s_r.wake_filter_enable;
        cmc_pkg::ADDR_INTCFG: rdv[15:0] = s_r.intcfg;
        cmc_pkg::ADDR_INTF:   rdv[cmc_pkg::INTF_WAKE_BIT] = s_r.wake_int_flag;
        cmc_pkg::ADDR_ERRC: begin
          rdv[cmc_pkg::ERRC_TX_LSB +: 8] = s_r.tec;
          rdv[cmc_pkg::ERRC_RX_LSB +: 8] = s_r.rec;
        end
        cmc_pkg::ADDR_TXCON: begin
          for (int i = 0; i < cmc_pkg::NUM_TXB; i++) begin
            rdv[i*cmc_pkg::TXC_STRIDE + cmc_pkg::TXC_PRI_LSB +: 2] =
              s_r.pri[i];
            rdv[i*cmc_pkg::TXC_STRIDE + cmc_pkg::TXC_REQ_BIT] = s_r.tx_request_bit[i];
            rdv[i*cmc_pkg::TXC_STRIDE + cmc_pkg::TXC_ABT_BIT] = s_r.tx_aborted_flag[i];
          end
        end
        cmc_pkg::ADDR_TXDLC: begin
          for (int i = 0; i < cmc_pkg::NUM_TXB; i++) begin
            rdv[i*cmc_pkg::DLC_STRIDE +: 4] = s_r.txdlc[i];
          end
        end
        default: map = 1'b0;
      endcase
    end

    // ---- apb answer: one wait state, pready for one cycle
    s_nxt.pready  = access;
    s_nxt.pslverr = access & ~map;
    if (access) begin
      s_nxt.prdata = rdv;
    end

    // ---- bit timing and idle detection
    s_nxt.bcnt = tick ? 16'h0000 : s_r.bcnt + 16'h0001;
    if (tick) begin
      if (rx_f != cmc_pkg::RECESSIVE) begin
        s_nxt.idle = 4'h0;
      end else if (s_r.idle != cmc_pkg::IDLE_BITS) begin
        s_nxt.idle = s_r.idle + 4'h1;
      end
    end
    if (s_r.idle == cmc_pkg::IDLE_BITS) begin
      s_nxt.hold_tx = 1'b0;
    end

    // ---- mode transition: an active mode is left only on an idle bus; init and disable are left at once
    if ((s_r.mst == cmc_pkg::MS_PENDING) &&
        (!active || (s_r.idle == cmc_pkg::IDLE_BITS)) &&
        !((s_r.req == cmc_pkg::MODE_INIT) &&
          (engine_tx_busy || s_r.txact))) begin
      s_nxt.cur     = s_r.req;
      s_nxt.mst     = cmc_pkg::MS_STEADY;
      s_nxt.idle    = 4'h0;
      s_nxt.hold_tx = tx_mode(s_r.req);
      if (!tx_mode(s_r.req)) begin
        s_nxt.txact = 1'b0;
      end
    end

    // ---- transmit completion clears before software writes
    if (s_r.txact && (engine_tx_done || engine_tx_err)) begin
      s_nxt.txact = 1'b0;
      if (engine_tx_done) begin
        s_nxt.tx_request_bit[s_r.sel] = 1'b0;
      end
    end

    // ---- register writes
    if (wr_en && map) begin
      if (paddr[7:5] == cmc_pkg::ADDR_FILT[7:5]) begin
        if (cfg_ok) begin
          s_nxt.filt[paddr[4:2]] = pwdata[29:0];
        end
      end else begin
        case (paddr)
          cmc_pkg::ADDR_CTRL: begin
            nm = pwdata[cmc_pkg::CTRL_REQ_LSB +: 3];
            s_nxt.req = nm;
            s_nxt.mst = (nm != s_nxt.cur) ? cmc_pkg::MS_PENDING :
                                            cmc_pkg::MS_STEADY;
            abort_all = (nm == cmc_pkg::MODE_DISABLE) && s_r.hold_tx;
          end
          cmc_pkg::ADDR_CFG1: begin
            if (cfg_ok) begin
              s_nxt.bitper = pwdata[15:0];
            end
          end
          cmc_pkg::ADDR_CFG2: begin
            if (cfg_ok) begin
              s_nxt.wake_filter_enable = pwdata[cmc_pkg::CFG2_WAKE_FILTER_ENABLE_BIT];
            end
          end
          cmc_pkg::ADDR_INTCFG: begin
            if (cfg_ok) begin
              s_nxt.intcfg = pwdata[15:0];
            end
          end
          cmc_pkg::ADDR_INTF: begin
            if (pwdata[cmc_pkg::INTF_WAKE_BIT]) begin
              s_nxt.wake_int_flag = 1'b0;
            end
          end
          cmc_pkg::ADDR_TXCON: begin
            for (int i = 0; i < cmc_pkg::NUM_TXB; i++) begin
              s_nxt.pri[i] =
                pwdata[i*cmc_pkg::TXC_STRIDE + cmc_pkg::TXC_PRI_LSB +: 2];
              if (pwdata[i*cmc_pkg::TXC_STRIDE + cmc_pkg::TXC_REQ_BIT]) begin
                s_nxt.tx_request_bit[i] = 1'b1;
                s_nxt.tx_aborted_flag[i] = 1'b0;
              end else if (s_r.tx_request_bit[i]) begin
                s_nxt.tx_request_bit[i] = 1'b0;
                s_nxt.tx_aborted_flag[i] = 1'b1;
              end
            end
          end
          cmc_pkg::ADDR_TXDLC: begin
            for (int i = 0; i < cmc_pkg::NUM_TXB; i++) begin
              dl = pwdata[i*cmc_pkg::DLC_STRIDE +: 4];
              s_nxt.txdlc[i] = (dl > cmc_pkg::MAX_DLC) ?
                               cmc_pkg::MAX_DLC : dl;
            end
          end
          default: ;
        endcase
      end
    end
    if (abort_all) begin
      s_nxt.tx_aborted_flag = s_nxt.tx_aborted_flag | s_nxt.tx_request_bit;
      s_nxt.tx_request_bit = 3'h0;
    end

    // ---- hardware sets win over any clear in the same cycle
    if (engine_rtr_hit && (engine_rtr_buf < 2'(cmc_pkg::NUM_TXB))) begin
      s_nxt.tx_request_bit[engine_rtr_buf] = 1'b1;
      s_nxt.tx_aborted_flag[engine_rtr_buf] = 1'b0;
    end
    if ((s_r.cur == cmc_pkg::MODE_DISABLE) && s_r.rx_q && !rx_f) begin
      s_nxt.wake_int_flag = 1'b1;
    end
    s_nxt.rx_q = rx_f;

    // ---- error counters
    case (s_r.cur)
      cmc_pkg::MODE_INIT: begin
        s_nxt.tec = 8'h00;
        s_nxt.rec = 8'h00;
      end
      cmc_pkg::MODE_NORMAL, cmc_pkg::MODE_LOOPBACK: begin
        if (engine_tx_err && (s_r.tec != 8'hff)) begin
          s_nxt.tec = s_r.tec + 8'h01;
        end
        if (engine_rx_err && (s_r.rec != 8'hff)) begin
          s_nxt.rec = s_r.rec + 8'h01;
        end
      end
      default: ;
    endcase

    // ---- transmit arbitration: highest priority, lowest index on a tie
    for (int i = 0; i < cmc_pkg::NUM_TXB; i++) begin
      if (s_r.tx_request_bit[i] && (!fnd || (s_r.pri[i] > bp))) begin
        fnd = 1'b1;
        bp  = s_r.pri[i];
        bi  = 2'(i);
      end
    end
    if (!s_r.txact && tx_mode(s_r.cur) && (s_r.mst == cmc_pkg::MS_STEADY) &&
        !s_r.hold_tx && !engine_tx_busy && fnd && !abort_all) begin
      s_nxt.tx_start = 1'b1;
      s_nxt.txact    = 1'b1;
      s_nxt.sel      = bi;
      s_nxt.dlc_out  = s_r.txdlc[bi];
    end

    // ---- error and overload frames
    s_nxt.err_send = engine_err_det & s_r.ack_en;
    if (engine_sof) begin
      s_nxt.ovl_run = 2'h0;
    end else if (engine_ovl_cond && s_r.ack_en &&
                 (s_r.ovl_run < cmc_pkg::MAX_OVL)) begin
      s_nxt.ovl_send = 1'b1;
      s_nxt.ovl_run  = s_r.ovl_run + 2'h1;
    end

    // ---- pin ownership and engine enables follow the entered mode
    s_nxt.tx_en  = tx_mode(s_nxt.cur);
    s_nxt.rx_en  = (s_nxt.cur != cmc_pkg::MODE_INIT) &&
                   (s_nxt.cur != cmc_pkg::MODE_DISABLE);
    s_nxt.ack_en = tx_mode(s_nxt.cur);
    s_nxt.accept_all = (s_nxt.cur == cmc_pkg::MODE_ERRREC);
    s_nxt.pin_oe = (s_nxt.cur == cmc_pkg::MODE_NORMAL);
    s_nxt.pin_tx = (s_nxt.cur == cmc_pkg::MODE_NORMAL) ?
                   engine_tx_bit : cmc_pkg::RECESSIVE;
    s_nxt.pins_owned = (s_nxt.cur == cmc_pkg::MODE_NORMAL) ||
                       (s_nxt.cur == cmc_pkg::MODE_LISTEN) ||
                       (s_nxt.cur == cmc_pkg::MODE_ERRREC);
    if (!s_nxt.rx_en) begin
      s_nxt.eng_rx = cmc_pkg::RECESSIVE;
    end else if (s_nxt.cur == cmc_pkg::MODE_LOOPBACK) begin
      s_nxt.eng_rx = engine_tx_bit;
    end else begin
      s_nxt.eng_rx = rx_f;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r        <= '0;
      s_r.req    <= cmc_pkg::RST_MODE;
      s_r.cur    <= cmc_pkg::RST_MODE;
      s_r.mst    <= cmc_pkg::MS_STEADY;
      s_r.bitper <= cmc_pkg::RST_BIT_PERIOD;
      s_r.rx_q   <= cmc_pkg::RECESSIVE;
      s_r.eng_rx <= cmc_pkg::RECESSIVE;
      s_r.pin_tx <= cmc_pkg::RECESSIVE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata            = s_r.prdata;
  assign pready            = s_r.pready;
  assign pslverr           = s_r.pslverr;
  assign bus_transmit_pin  = s_r.pin_tx;
  assign bus_transmit_oe   = s_r.pin_oe;
  assign bus_pins_owned    = s_r.pins_owned;
  assign engine_rx_bit     = s_r.eng_rx;
  assign engine_tx_en      = s_r.tx_en;
  assign engine_rx_en      = s_r.rx_en;
  assign engine_ack_en     = s_r.ack_en;
  assign engine_accept_all = s_r.accept_all;
  assign tx_start          = s_r.tx_start;
  assign tx_buf_sel        = s_r.sel;
  assign tx_dlc            = s_r.dlc_out;
  assign err_frame_send    = s_r.err_send;
  assign ovl_frame_send    = s_r.ovl_send;
endmodule

// ==== core/cmc_pkg.sv ====
// package: constants and types for the CAN operating-mode controller
package cmc_pkg;
  // ==========================================================================
  // clock and timing
  localparam int CLK_HZ      = 200_000_000;
  localparam int MAX_BPS     = 1_000_000;
  localparam int BIT_CYC_MIN = CLK_HZ / MAX_BPS;
  localparam int LPF_NS      = 50;
  localparam int LPF_CYC     = (LPF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] IDLE_BITS = 4'hb;
  localparam logic       RECESSIVE = 1'b1;

  // ==========================================================================
  // mode codes
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_DISABLE  = 3'h1;
  localparam logic [2:0] MODE_LOOPBACK = 3'h2;
  localparam logic [2:0] MODE_LISTEN   = 3'h3;
  localparam logic [2:0] MODE_INIT     = 3'h4;
  localparam logic [2:0] MODE_ERRREC   = 3'h7;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CFG1   = 8'h04;
  localparam logic [7:0] ADDR_CFG2   = 8'h08;
  localparam logic [7:0] ADDR_INTCFG = 8'h0c;
  localparam logic [7:0] ADDR_INTF   = 8'h10;
  localparam logic [7:0] ADDR_ERRC   = 8'h14;
  localparam logic [7:0] ADDR_TXCON  = 8'h18;
  localparam logic [7:0] ADDR_TXDLC  = 8'h1c;
  localparam logic [7:0] ADDR_FILT   = 8'h20;

  // ==========================================================================
  // field positions
  localparam int CTRL_REQ_LSB    = 8;
  localparam int CTRL_CUR_LSB    = 5;
  localparam int CFG2_WAKE_FILTER_ENABLE_BIT = 14;
  localparam int INTF_WAKE_BIT   = 0;
  localparam int ERRC_TX_LSB     = 0;
  localparam int ERRC_RX_LSB     = 8;
  localparam int TXC_STRIDE      = 8;
  localparam int TXC_PRI_LSB     = 0;
  localparam int TXC_REQ_BIT     = 3;
  localparam int TXC_ABT_BIT     = 6;
  localparam int DLC_STRIDE      = 4;
  localparam int FILT_EXT_BIT    = 29;

  // ==========================================================================
  // frame and buffer sizes
  localparam int BASE_ID_W   = 11;
  localparam int EXT_ID_W    = 18;
  localparam int FULL_ID_W   = BASE_ID_W + EXT_ID_W;
  localparam logic [3:0] MAX_DLC = 4'h8;
  localparam int NUM_FILT    = 6;
  localparam int NUM_MASK    = 2;
  localparam int FILT_HI     = 2;
  localparam int NUM_TXB     = 3;
  localparam logic [1:0] MAX_OVL = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic [2:0]  RST_MODE       = MODE_INIT;
  localparam logic [15:0] RST_BIT_PERIOD = 16'h00c8;

  typedef enum logic {MS_STEADY, MS_PENDING} cmc_mstate_type;
endpackage

// ==== core/cmc_lp_filter.sv ====
// module: low-pass filter for the bus receive input
`timescale 1ns/1ps
module cmc_lp_filter (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control and data
  input  wire logic filt_on,
  input  wire logic raw_in,
  output logic      clean_out
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       out;
  } cmc_lpf_state_type;

  cmc_lpf_state_type s_r;
  cmc_lpf_state_type s_nxt;

  // ==========================================================================
  // filter: a level must stand for the full window before it passes
  always_comb begin
    s_nxt = s_r;
    if (!filt_on) begin
      s_nxt.out = raw_in;
      s_nxt.cnt = 8'h00;
    end else if (raw_in == s_r.out) begin
      s_nxt.cnt = 8'h00;
    end else if (s_r.cnt == 8'(cmc_pkg::LPF_CYC - 1)) begin
      s_nxt.out = raw_in;
      s_nxt.cnt = 8'h00;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r     <= '0;
      s_r.out <= cmc_pkg::RECESSIVE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign clean_out = s_r.out;
endmodule

// ==== dv/cmc_mode_chk.sv ====
// checker: port-level timing rules of the mode controller
`timescale 1ns/1ps
module cmc_mode_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb answer
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic bus_transmit_pin,
  input wire logic bus_transmit_oe,
  input wire logic bus_pins_owned,
  // engine
  input wire logic engine_tx_done,
  input wire logic engine_tx_err,
  input wire logic engine_err_det,
  input wire logic engine_ovl_cond,
  input wire logic engine_sof,
  input wire logic engine_ack_en,
  input wire logic tx_start,
  input wire logic err_frame_send,
  input wire logic ovl_frame_send
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // helper state
  logic       fly_r;
  logic [1:0] ovl_r;
  // saturate at 3 so a third overload is still seen after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fly_r <= 1'b0;
      ovl_r <= 2'h0;
    end else begin
      fly_r <= tx_start | (fly_r & ~engine_tx_done & ~engine_tx_err);
      if (engine_sof)
        ovl_r <= 2'h0;
      else if (ovl_frame_send && ovl_r != 2'h3)
        ovl_r <= ovl_r + 2'h1;
    end
  end
  // ==========================================================================
  // assertions
  sequence acc_wait_s; psel && penable && !pready; endsequence
  sequence answer_s; pready ##1 !pready; endsequence
  apb_answer_a: assert property (acc_wait_s |=> answer_s)
    else $error("apb answer not one cycle after access");
  err_resp_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  tx_recess_a: assert property (!bus_transmit_oe |-> bus_transmit_pin)
    else $error("released transmit pin not recessive");
  oe_owned_a: assert property (bus_transmit_oe |-> bus_pins_owned)
    else $error("transmit driven while pins released");
  one_frame_a: assert property (tx_start |-> !fly_r)
    else $error("frame start while a frame is in flight");
  err_frame_a: assert property (err_frame_send |->
    $past(engine_err_det) && $past(engine_ack_en))
    else $error("error frame without detected error");
  err_cause_a: assert property (engine_err_det && engine_ack_en
    |=> err_frame_send)
    else $error("detected error sent no error frame");
  ovl_cause_a: assert property (ovl_frame_send |->
    $past(engine_ovl_cond))
    else $error("overload frame without cause");
  ovl_limit_a: assert property (ovl_r <= 2'h2)
    else $error("more than two overload frames in a row");
endmodule

// ==== dv/cmc_bus_node.sv ====
// model: remote CAN node and protocol engine answering a started frame
`timescale 1ns/1ps
module cmc_bus_node (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // controller side
  input  wire logic tx_start,
  input  wire logic slow,
  input  wire logic dom_req,
  output logic      bus_rx,
  output logic      tx_busy,
  output logic      tx_done
);
  int   cnt;
  logic tgl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      tgl <= 1'b1;
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tgl <= ~tgl;
      if (tx_start) begin
        cnt <= slow ? 1500 : 40;
        tx_busy <= 1'b1;
      end else if (cnt == 1) begin
        cnt <= 0;
        tx_busy <= 1'b0;
        tx_done <= 1'b1;
      end else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
  // frame bits change every cycle; at the even bit period every tick samples the same recessive level
  assign bus_rx = (tx_busy ? tgl : 1'b1) & ~dom_req;
endmodule

// ==== dv/test_cmc_mode_ctrl.sv ====
// testbench: registers, mode changes and transmit of the mode controller
`timescale 1ns/1ps
module test_cmc_mode_ctrl;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_pin, tx_pin, tx_oe, owned, tx_busy, tx_done, slow, dom;
  logic        tx_start, err_fs, ovl_fs, slp, tbit;
  logic [1:0]  buf_sel;
  logic [3:0]  ev, ex;
  logic [7:0]  paddr, rnd;
  logic [31:0] pwdata, prdata, txw;
  typedef struct {logic rd; logic [31:0] d; logic er;} cmc_note_type;
  cmc_note_type nq[$];
  logic [1:0]   tq[$];
  int           fail_count, tests_run, ovl_seen, err_seen, k;
  cmc_mode_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_receive_pin(rx_pin), .bus_transmit_pin(tx_pin),
    .bus_transmit_oe(tx_oe), .bus_pins_owned(owned), .sleep_req(slp),
    .engine_tx_bit(tbit), .engine_tx_busy(tx_busy),
    .engine_tx_done(tx_done), .engine_tx_err(ex[0]), .engine_rx_err(ev[0]),
    .engine_err_det(ev[1]), .engine_ovl_cond(ev[2]), .engine_sof(ev[3]),
    .engine_rtr_hit(ex[1]), .engine_rtr_buf(ex[3:2]), .engine_rx_bit(),
    .engine_tx_en(), .engine_rx_en(), .engine_ack_en(),
    .engine_accept_all(), .tx_start(tx_start), .tx_buf_sel(buf_sel),
    .tx_dlc(), .err_frame_send(err_fs), .ovl_frame_send(ovl_fs));
  cmc_bus_node u_node (.pclk(pclk), .presetn(presetn), .tx_start(tx_start),
    .slow(slow), .dom_req(dom), .bus_rx(rx_pin), .tx_busy(tx_busy),
    .tx_done(tx_done));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ==========================================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, s);
      fail_count++;
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task hang;
    fail_count++;
    $display("[FAIL] wait exp done got timeout");
    wrap_up;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] e, input logic er);
    nq.push_back('{!w && !er, e, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 20) hang;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask
  task pulse(input logic [3:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 4'h0;
    @(posedge pclk);
  endtask
  task wait_sig(input int n, input logic lvl);
    for (k = 0; k < n && (lvl ? tx_start : tx_busy) !== lvl; k++)
      @(negedge pclk);
    if (k == n) hang;
    @(posedge pclk);
  endtask
  // ==========================================================================
  // output watcher
  always @(posedge pclk) begin
    if (pready === 1'b1 && nq.size() > 0) begin
      chk("pslverr", 32'(nq[0].er), 32'(pslverr));
      if (nq[0].rd) chk("prdata", nq[0].d, prdata);
      void'(nq.pop_front());
    end
    if (tx_start === 1'b1 && tq.size() > 0)
      chk("tx_buf_sel", 32'(tq.pop_front()), 32'(buf_sel));
    if (ovl_fs === 1'b1) ovl_seen++;
    if (err_fs === 1'b1) err_seen++;
  end
  // ==========================================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, slow, dom, presetn, slp} = '0;
    {paddr, pwdata, ev, ex, txw} = '0;
    tbit = 1'b1;
    {fail_count, tests_run, ovl_seen, err_seen} = '0;
    rnd = 8'h14;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rnd = lfsr(rnd);
    wr(cmc_pkg::ADDR_INTCFG, {4{rnd}});
    rd(cmc_pkg::ADDR_INTCFG, {16'h0, rnd, rnd});
    wr(cmc_pkg::ADDR_CFG2, 32'h4000);
    rd(cmc_pkg::ADDR_CFG2, 32'h4000);
    rd(cmc_pkg::ADDR_CTRL, 32'h480);
    wr(cmc_pkg::ADDR_CTRL, 32'h0);
    rd(cmc_pkg::ADDR_CTRL, 32'h0);
    chk("bus_transmit_oe", 32'h1, 32'(tx_oe));
    wr(cmc_pkg::ADDR_CFG2, 32'h0);
    rd(cmc_pkg::ADDR_CFG2, 32'h4000);
    apb(1'b0, 8'h44, 32'h0, 32'h0, 1'b1);
    pulse(4'h1);
    rd(cmc_pkg::ADDR_ERRC, 32'h100);
    pulse(4'h8);
    repeat (3) pulse(4'h4);
    pulse(4'h2);
    repeat (4) @(posedge pclk);
    chk("ovl_frame_send", 32'h2, 32'(ovl_seen));
    chk("err_frame_send", 32'h1, 32'(err_seen));
    rnd = lfsr(rnd);
    txw = {28'h0, 2'b10, rnd[1:0]};
    tq.push_back(2'h0);
    wr(cmc_pkg::ADDR_TXCON, txw);
    wait_sig(4000, 1'b1);
    repeat (100) @(posedge pclk);
    rd(cmc_pkg::ADDR_TXCON, {30'h0, rnd[1:0]});
    slow <= 1'b1;
    tq.push_back(2'h0);
    wr(cmc_pkg::ADDR_TXCON, txw);
    wait_sig(100, 1'b1);
    wr(cmc_pkg::ADDR_CTRL, 32'h400);
    rd(cmc_pkg::ADDR_CTRL, 32'h400);
    wait_sig(2000, 1'b0);
    repeat (2300) @(posedge pclk);
    rd(cmc_pkg::ADDR_CTRL, 32'h480);
    rd(cmc_pkg::ADDR_ERRC, 32'h0);
    slow <= 1'b0;
    wr(cmc_pkg::ADDR_CTRL, 32'h0);
    wr(cmc_pkg::ADDR_TXCON, txw);
    wr(cmc_pkg::ADDR_CTRL, 32'h100);
    rd(cmc_pkg::ADDR_TXCON, {25'h0, 1'b1, 4'h0, rnd[1:0]});
    rd(cmc_pkg::ADDR_CTRL, 32'h100);
    repeat (2300) @(posedge pclk);
    rd(cmc_pkg::ADDR_CTRL, 32'h120);
    chk("bus_pins_owned", 32'h0, 32'(owned));
    dom <= 1'b1;
    repeat (3) @(posedge pclk);
    dom <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(cmc_pkg::ADDR_INTF, 32'h0);
    dom <= 1'b1;
    repeat (30) @(posedge pclk);
    dom <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(cmc_pkg::ADDR_INTF, 32'h1);
    wr(cmc_pkg::ADDR_INTF, 32'h1);
    rd(cmc_pkg::ADDR_INTF, 32'h0);
    ex <= 4'h6;
    @(posedge pclk);
    ex <= 4'h0;
    rd(cmc_pkg::ADDR_TXCON, {20'h0, 4'h8, 2'h1, 4'h0, rnd[1:0]});
    wrap_up;
  end
endmodule
bind cmc_mode_ctrl cmc_mode_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .bus_transmit_pin(bus_transmit_pin), .bus_transmit_oe(bus_transmit_oe),
  .bus_pins_owned(bus_pins_owned), .engine_tx_done(engine_tx_done),
  .engine_tx_err(engine_tx_err), .engine_err_det(engine_err_det),
  .engine_ovl_cond(engine_ovl_cond), .engine_sof(engine_sof),
  .engine_ack_en(engine_ack_en), .tx_start(tx_start),
  .err_frame_send(err_frame_send), .ovl_frame_send(ovl_frame_send));
